// [hw/kss_top.sv]
`timescale 1ns/1ps
`include "kss_cfg.svh"

module kss_top
	import kss_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic init_n,
	input wire logic keyboard_select_n,
	input wire logic host_write_strobe_n,
	input wire logic host_read_strobe_n,
	input wire logic cd_select,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_n,
	input wire logic keyboard_bit_clock,
	input wire logic keyboard_serial_in,
	output logic keyboard_serial_out,
	output logic rx_char_waiting_n,
	output logic tx_buffer_free_n,
	output logic keyboard_irq_n,
	output logic vector_relocate_n
);

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [`KSS_SYNC_WIDTH-1:0] pins_raw;
	logic [`KSS_SYNC_WIDTH-1:0] pins_s;
	logic bclk_s, rxd_s, init_s, cs_n_s, wr_n_s, rd_n_s, cd_s;
	logic [7:0] din_s;

	assign pins_raw = {keyboard_bit_clock, keyboard_serial_in, init_n, keyboard_select_n,
		host_write_strobe_n, host_read_strobe_n, cd_select, host_data_in};

	kss_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in(pins_raw),
		.pin_sync(pins_s)
	);

	assign {bclk_s, rxd_s, init_s, cs_n_s, wr_n_s, rd_n_s, cd_s, din_s} = pins_s;

	////////////////////////////////////////////////////////////////////////////////
	// host bus decode

	logic wr_act, rd_act;
	logic wr_act_r, wr_act_nxt;
	logic rd_act_r, rd_act_nxt;
	logic rd_cd_r, rd_cd_nxt;
	logic bclk_d_r, bclk_d_nxt;
	logic wr_pulse, wr_ctrl, wr_data, rd_data_end, bit_tick;

	assign wr_act = !cs_n_s && !wr_n_s;
	assign rd_act = !cs_n_s && !rd_n_s;
	assign wr_pulse = wr_act && !wr_act_r;
	assign wr_ctrl = wr_pulse && (cd_s == `KSS_CD_CTRL);
	assign wr_data = wr_pulse && (cd_s == `KSS_CD_DATA);
	assign rd_data_end = rd_act_r && !rd_act && (rd_cd_r == `KSS_CD_DATA);
	// one tick per rising edge of the shared 16x clock, counted on clk
	assign bit_tick = bclk_s && !bclk_d_r;

	always_comb begin
		wr_act_nxt = wr_act;
		rd_act_nxt = rd_act;
		rd_cd_nxt = rd_act ? cd_s : rd_cd_r;
		bclk_d_nxt = bclk_s;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_act_r <= 1'b0;
			rd_act_r <= 1'b0;
			rd_cd_r <= 1'b0;
			// matches the idle level of the synchroniser so no false tick follows reset
			bclk_d_r <= 1'b1;
		end else begin
			wr_act_r <= wr_act_nxt;
			rd_act_r <= rd_act_nxt;
			rd_cd_r <= rd_cd_nxt;
			bclk_d_r <= bclk_d_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode / command control

	logic expect_mode_r, expect_mode_nxt;
	kss_mode_s mode_r, mode_nxt;
	kss_cmd_s cmd_r, cmd_nxt;
	kss_cmd_s din_cmd;
	logic soft_rst, err_reset;

	assign din_cmd = kss_cmd_s'(din_s);
	assign soft_rst = !init_s || (wr_ctrl && !expect_mode_r && din_cmd.int_reset);
	assign err_reset = wr_ctrl && !expect_mode_r && din_cmd.err_reset;

	always_comb begin
		expect_mode_nxt = expect_mode_r;
		mode_nxt = mode_r;
		cmd_nxt = cmd_r;
		if (wr_ctrl) begin
			if (expect_mode_r) begin
				mode_nxt = kss_mode_s'(din_s);
				expect_mode_nxt = 1'b0;
			end else begin
				cmd_nxt = din_cmd;
				cmd_nxt.err_reset = 1'b0;
			end
		end
		if (soft_rst) begin
			expect_mode_nxt = 1'b1;
			cmd_nxt = kss_cmd_s'(`KSS_CMD_RESET);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			expect_mode_r <= 1'b1;
			mode_r <= kss_mode_s'(`KSS_MODE_RESET);
			cmd_r <= kss_cmd_s'(`KSS_CMD_RESET);
		end else begin
			expect_mode_r <= expect_mode_nxt;
			mode_r <= mode_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmitter

	logic [7:0] txbuf_r, txbuf_nxt;
	logic txbuf_full_r, txbuf_full_nxt;
	logic tx_busy_r, tx_busy_nxt;
	logic [10:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_tick_r, tx_tick_nxt;
	logic [3:0] tx_bits_r, tx_bits_nxt;
	logic txd_r, txd_nxt;
	logic tx_start;

	assign tx_start = !tx_busy_r && txbuf_full_r && cmd_r.transmit_enable_bit
		&& (`KSS_CTS_LEVEL == 1'b0);

	always_comb begin
		txbuf_nxt = txbuf_r;
		txbuf_full_nxt = txbuf_full_r;
		tx_busy_nxt = tx_busy_r;
		tx_sh_nxt = tx_sh_r;
		tx_tick_nxt = tx_tick_r;
		tx_bits_nxt = tx_bits_r;
		if (tx_start) begin
			// frame is start, eight data bits lsb first, then stop bits
			tx_sh_nxt = {2'b11, txbuf_r, 1'b0};
			tx_bits_nxt = (mode_r.stop_bits >= `KSS_STOP_TWO_MIN) ?
				`KSS_FRAME_TWO_STOP : `KSS_FRAME_ONE_STOP;
			tx_tick_nxt = 4'h0;
			tx_busy_nxt = 1'b1;
			txbuf_full_nxt = 1'b0;
		end else if (tx_busy_r && bit_tick) begin
			tx_tick_nxt = tx_tick_r + 4'h1;
			if (tx_tick_r == `KSS_LAST_TICK) begin
				tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
				tx_bits_nxt = tx_bits_r - 4'h1;
				if (tx_bits_r == 4'h1)
					tx_busy_nxt = 1'b0;
			end
		end
		if (wr_data) begin
			txbuf_nxt = din_s;
			txbuf_full_nxt = 1'b1;
		end
		if (soft_rst) begin
			tx_busy_nxt = 1'b0;
			txbuf_full_nxt = 1'b0;
		end
		txd_nxt = cmd_nxt.send_break ? 1'b0 : (tx_busy_nxt ? tx_sh_nxt[0] : 1'b1);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txbuf_r <= 8'h00;
			txbuf_full_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_sh_r <= 11'h7ff;
			tx_tick_r <= 4'h0;
			tx_bits_r <= 4'h0;
			txd_r <= 1'b1;
		end else begin
			txbuf_r <= txbuf_nxt;
			txbuf_full_r <= txbuf_full_nxt;
			tx_busy_r <= tx_busy_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_tick_r <= tx_tick_nxt;
			tx_bits_r <= tx_bits_nxt;
			txd_r <= txd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receiver and its flags

	logic [7:0] rx_char;
	logic rx_done, rx_frame_err;
	logic rx_ready_r, rx_ready_nxt;
	logic overrun_r, overrun_nxt;
	logic frame_err_r, frame_err_nxt;

	kss_rx u_rx (
		.clk(clk),
		.sys_rst(sys_rst),
		.soft_rst(soft_rst),
		.enable(cmd_r.receive_enable_bit),
		.bit_tick(bit_tick),
		.serial_in(rxd_s),
		.rx_char(rx_char),
		.rx_done(rx_done),
		.rx_frame_err(rx_frame_err)
	);

	// a new character in the cycle of a clear still sets the flag
	always_comb begin
		rx_ready_nxt = rx_ready_r;
		overrun_nxt = overrun_r;
		frame_err_nxt = frame_err_r;
		if (rd_data_end)
			rx_ready_nxt = 1'b0;
		if (err_reset) begin
			overrun_nxt = 1'b0;
			frame_err_nxt = 1'b0;
		end
		if (rx_done) begin
			rx_ready_nxt = 1'b1;
			if (rx_ready_r && !rd_data_end)
				overrun_nxt = 1'b1;
			if (rx_frame_err)
				frame_err_nxt = 1'b1;
		end
		if (soft_rst) begin
			rx_ready_nxt = 1'b0;
			overrun_nxt = 1'b0;
			frame_err_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_ready_r <= 1'b0;
			overrun_r <= 1'b0;
			frame_err_r <= 1'b0;
		end else begin
			rx_ready_r <= rx_ready_nxt;
			overrun_r <= overrun_nxt;
			frame_err_r <= frame_err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status, read data and pins

	kss_status_s status;
	logic [7:0] dout_r, dout_nxt;

	always_comb begin
		status = '0;
		status.tx_ready = !txbuf_full_r;
		status.rx_ready = rx_ready_r;
		status.tx_empty = !txbuf_full_r && !tx_busy_r;
		status.overrun_err = overrun_r;
		status.frame_err = frame_err_r;
		dout_nxt = (cd_s == `KSS_CD_CTRL) ? 8'(status) : rx_char;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			dout_r <= 8'h00;
		else
			dout_r <= dout_nxt;
	end

	assign host_data_out = dout_r;
	assign host_data_oe_n = !rd_act_r;
	assign keyboard_serial_out = txd_r;
	assign rx_char_waiting_n = !rx_ready_r;
	assign tx_buffer_free_n = !(!txbuf_full_r && (`KSS_CTS_LEVEL == 1'b0)
		&& cmd_r.transmit_enable_bit);
	assign keyboard_irq_n = rx_char_waiting_n && tx_buffer_free_n;
	assign vector_relocate_n = !cmd_r.dtr;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	status_read_a: assert property ((rd_act && cd_s) |=>
		(!host_data_oe_n && host_data_out == 8'($past(status))))
		else $error("status read not answered");
	tx_status_bit_a: assert property ((rd_act && cd_s) |=>
		(host_data_out[0] == !$past(txbuf_full_r)))
		else $error("status transmit-ready bit not buffer empty");
	tx_pin_a: assert property (!tx_buffer_free_n |->
		(!txbuf_full_r && cmd_r.transmit_enable_bit))
		else $error("transmit-ready pin without its conditions");
	tx_start_a: assert property ($rose(tx_busy_r) |->
		($past(cmd_r.transmit_enable_bit) && $past(txbuf_full_r)))
		else $error("transmission began while disabled");
	start_bit_a: assert property (($rose(tx_busy_r) && !cmd_r.send_break) |->
		!keyboard_serial_out)
		else $error("frame did not open with a start bit");
	rx_clear_a: assert property ((rd_data_end && !rx_done && !soft_rst) |=>
		rx_char_waiting_n)
		else $error("receive-ready not cleared by data read");
	tx_clear_a: assert property ((wr_data && !soft_rst) |=>
		(tx_buffer_free_n && txbuf_full_r))
		else $error("transmit-ready not cleared by load");
	int_reset_a: assert property ((wr_ctrl && !expect_mode_r && din_s[`KSS_CMD_IR_BIT]) |=>
		(expect_mode_r && cmd_r == kss_cmd_s'(`KSS_CMD_RESET)))
		else $error("internal reset did not return to mode format");
	cmd_after_mode_a: assert property ((wr_ctrl && expect_mode_r && init_s) |=>
		(!expect_mode_r && mode_r == $past(din_s)))
		else $error("mode instruction not taken");
	init_idle_a: assert property (!init_s |=>
		(expect_mode_r && !tx_busy_r && tx_buffer_free_n))
		else $error("init low did not idle the port");

endmodule

// [hw/kss_cfg.svh]
`ifndef KSS_CFG_SVH
`define KSS_CFG_SVH

// host i/o addresses; address bit zero reaches the part as the control/data select
`define KSS_ADDR_DATA 8'h10
`define KSS_ADDR_CTRL 8'h11
`define KSS_CD_CTRL 1'h1
`define KSS_CD_DATA 1'h0

// command bit that starts an internal reset
`define KSS_CMD_IR_BIT 6
`define KSS_CMD_RESET 8'h00
`define KSS_MODE_RESET 8'h4e

// mode stop field codes: 2'h3 is two stop bits, 2'h2 one and a half (sent as two)
`define KSS_STOP_TWO_MIN 2'h2

// clear-to-send is grounded on the board
`define KSS_CTS_LEVEL 1'h0

// 16x bit clock: mid-bit sample tick and last tick of a bit
`define KSS_MID_TICK 4'h7
`define KSS_LAST_TICK 4'hf
`define KSS_FRAME_ONE_STOP 4'ha
`define KSS_FRAME_TWO_STOP 4'hb
`define KSS_LAST_DATA_BIT 3'h7

// rates, for reference of the derived bit clock
`define KSS_CLK_HZ 10000000
`define KSS_BAUD 4800
`define KSS_OVERSAMPLE 16

// idle levels of the synchronised pins
`define KSS_SYNC_WIDTH 15
`define KSS_SYNC_IDLE 15'h7fff

`endif

// [hw/kss_pkg.sv]
package kss_pkg;

	typedef struct packed {
		logic enter_hunt;
		logic int_reset;
		logic rts;
		logic err_reset;
		logic send_break;
		logic receive_enable_bit;
		logic dtr;
		logic transmit_enable_bit;
	} kss_cmd_s;

	typedef struct packed {
		logic [1:0] stop_bits;
		logic even_parity;
		logic parity_en;
		logic [1:0] char_len;
		logic [1:0] rate_factor;
	} kss_mode_s;

	typedef struct packed {
		logic dsr;
		logic sync_det;
		logic frame_err;
		logic overrun_err;
		logic parity_err;
		logic tx_empty;
		logic rx_ready;
		logic tx_ready;
	} kss_status_s;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} kss_rx_state_e;

endpackage

// [hw/kss_sync.sv]
`timescale 1ns/1ps
`include "kss_cfg.svh"

module kss_sync
	import kss_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`KSS_SYNC_WIDTH-1:0] pin_in,
	output logic [`KSS_SYNC_WIDTH-1:0] pin_sync
);

	logic [`KSS_SYNC_WIDTH-1:0] meta_r;
	logic [`KSS_SYNC_WIDTH-1:0] sync_r;
	localparam logic [`KSS_SYNC_WIDTH-1:0] IDLE = `KSS_SYNC_IDLE;

	// two flops per pin; only the second stage is read
	genvar i;
	generate
		for (i = 0; i < `KSS_SYNC_WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					meta_r[i] <= IDLE[i];
					sync_r[i] <= IDLE[i];
				end else begin
					meta_r[i] <= pin_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign pin_sync = sync_r;

endmodule

// [hw/kss_rx.sv]
`timescale 1ns/1ps
`include "kss_cfg.svh"

module kss_rx
	import kss_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic soft_rst,
	input wire logic enable,
	input wire logic bit_tick,
	input wire logic serial_in,
	output logic [7:0] rx_char,
	output logic rx_done,
	output logic rx_frame_err
);

	kss_rx_state_e st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [2:0] bits_r, bits_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] char_r, char_nxt;
	logic done_r, done_nxt;
	logic ferr_r, ferr_nxt;
	logic prev_r;
	logic sample;

	assign sample = bit_tick && (cnt_r == `KSS_MID_TICK);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bits_nxt = bits_r;
		sh_nxt = sh_r;
		char_nxt = char_r;
		done_nxt = 1'b0;
		ferr_nxt = 1'b0;
		if (st_r != RX_IDLE && bit_tick)
			cnt_nxt = cnt_r + 4'h1;
		case (st_r)
			RX_IDLE: begin
				if (enable && prev_r && !serial_in) begin
					st_nxt = RX_START;
					cnt_nxt = 4'h0;
				end
			end
			RX_START: begin
				if (sample) begin
					st_nxt = serial_in ? RX_IDLE : RX_DATA;
					bits_nxt = 3'h0;
				end
			end
			RX_DATA: begin
				if (sample) begin
					sh_nxt = {serial_in, sh_r[7:1]};
					bits_nxt = bits_r + 3'h1;
					if (bits_r == `KSS_LAST_DATA_BIT)
						st_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (sample) begin
					char_nxt = sh_r;
					done_nxt = 1'b1;
					ferr_nxt = !serial_in;
					st_nxt = RX_IDLE;
				end
			end
			default: st_nxt = RX_IDLE;
		endcase
		if (soft_rst || !enable) begin
			st_nxt = RX_IDLE;
			done_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= RX_IDLE;
			cnt_r <= 4'h0;
			bits_r <= 3'h0;
			sh_r <= 8'h00;
			char_r <= 8'h00;
			done_r <= 1'b0;
			ferr_r <= 1'b0;
			prev_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bits_r <= bits_nxt;
			sh_r <= sh_nxt;
			char_r <= char_nxt;
			done_r <= done_nxt;
			ferr_r <= ferr_nxt;
			prev_r <= serial_in;
		end
	end

	assign rx_char = char_r;
	assign rx_done = done_r;
	assign rx_frame_err = ferr_r;

	false_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r == RX_START && sample && serial_in && !soft_rst && enable) |=> st_r == RX_IDLE)
		else $error("false start bit not dropped");
	rx_done_a: assert property (@(posedge clk) disable iff (sys_rst)
		rx_done |-> ($past(st_r) == RX_STOP && rx_char == $past(sh_r)))
		else $error("character not taken at stop bit");

endmodule

// [tb/kss_kb_model.sv]
`timescale 1ns/1ps

// keyboard far end: frames bytes onto the receive pin and decodes the transmit pin
module kss_kb_model (
	input wire logic bit_clk,
	input wire logic tx_line,
	output logic rx_line
);
	logic [7:0] got;
	int n_got;
	int flen;
	int ticks;
	event got_evt;

	initial begin
		rx_line = 1'b1;
		n_got = 0;
		ticks = 0;
		flen = 0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge bit_clk);
	endtask

	// start bit, eight bits lsb first, one stop; stop_ok low gives a framing fault
	task automatic send(input logic [7:0] b, input logic stop_ok);
		rx_line = 1'b0;
		tick(16);
		for (int i = 0; i < 8; i++) begin
			rx_line = b[i];
			tick(16);
		end
		rx_line = stop_ok;
		tick(16);
		rx_line = 1'b1;
		tick(16);
	endtask

	// low pulse on the receive pin, shorter than half a bit
	task automatic glitch();
		rx_line = 1'b0;
		tick(3);
		rx_line = 1'b1;
		tick(32);
	endtask

	// frame length in ticks from one start edge to the next
	always @(posedge bit_clk) begin
		ticks <= ticks + 1;
	end

	always begin
		@(negedge tx_line);
		flen = ticks;
		ticks = 0;
		tick(8);
		if (tx_line == 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				tick(16);
				got[i] = tx_line;
			end
			tick(16);
			n_got++;
			->got_evt;
		end
	end
endmodule

// [tb/kss_top_tb.sv]
`timescale 1ns/1ps
`include "kss_cfg.svh"

module kss_top_tb;
	import kss_pkg::*;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic init_n = 1'b1;
	logic keyboard_select_n = 1'b1;
	logic host_write_strobe_n = 1'b1;
	logic host_read_strobe_n = 1'b1;
	logic cd_select = 1'b0;
	logic [7:0] host_data_in = 8'h00;
	logic keyboard_bit_clock = 1'b0;
	logic [7:0] host_data_out;
	logic host_data_oe_n;
	logic keyboard_serial_in;
	logic keyboard_serial_out;
	logic rx_char_waiting_n;
	logic tx_buffer_free_n;
	logic keyboard_irq_n;
	logic vector_relocate_n;
	logic prev_oe = 1'b1;
	logic [7:0] exp_rd[$];
	logic [7:0] exp_tx[$];
	logic [7:0] b[5];
	int err_total = 0;
	int n_checks = 0;

	always #50 clk = ~clk;
	// bit clock compressed to 8 system clocks so frames stay short
	initial begin
		#37;
		forever #400 keyboard_bit_clock = ~keyboard_bit_clock;
	end

	kss_top u_kss_top (.clk(clk), .sys_rst(sys_rst), .init_n(init_n),
		.keyboard_select_n(keyboard_select_n), .host_write_strobe_n(host_write_strobe_n),
		.host_read_strobe_n(host_read_strobe_n), .cd_select(cd_select),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .keyboard_bit_clock(keyboard_bit_clock),
		.keyboard_serial_in(keyboard_serial_in), .keyboard_serial_out(keyboard_serial_out),
		.rx_char_waiting_n(rx_char_waiting_n), .tx_buffer_free_n(tx_buffer_free_n),
		.keyboard_irq_n(keyboard_irq_n), .vector_relocate_n(vector_relocate_n));

	kss_kb_model u_kss_kb_model (.bit_clk(keyboard_bit_clock), .tx_line(keyboard_serial_out),
		.rx_line(keyboard_serial_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic bus(input logic cd, input logic rd, input logic [7:0] d);
		int k;
		k = 0;
		@(negedge clk);
		cd_select = cd;
		host_data_in = d;
		keyboard_select_n = 1'b0;
		host_read_strobe_n = !rd;
		host_write_strobe_n = rd;
		if (rd) begin
			while (host_data_oe_n !== 1'b0 && k < 20) begin
				@(negedge clk);
				k++;
			end
		end else begin
			repeat (5) @(negedge clk);
		end
		@(negedge clk);
		keyboard_select_n = 1'b1;
		host_read_strobe_n = 1'b1;
		host_write_strobe_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic wr(input logic cd, input logic [7:0] d);
		bus(cd, 1'b0, d);
	endtask

	task automatic rd(input logic cd, input logic [7:0] exp);
		exp_rd.push_back(exp);
		bus(cd, 1'b1, 8'h00);
	endtask

	task automatic wait_rx();
		int k;
		k = 0;
		while (rx_char_waiting_n !== 1'b0 && k < 4000) begin
			@(negedge clk);
			k++;
		end
	endtask

	task automatic wait_tx(input int n);
		int k;
		k = 0;
		while (u_kss_kb_model.n_got < n && k < 6000) begin
			@(negedge clk);
			k++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// read data is compared where the bus turns round
	always @(negedge clk) begin
		if (prev_oe === 1'b1 && host_data_oe_n === 1'b0)
			chk(host_data_out, exp_rd.pop_front());
		prev_oe <= host_data_oe_n;
	end

	always @(u_kss_kb_model.got_evt) begin
		chk(u_kss_kb_model.got, exp_tx.pop_front());
	end

	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h0000_28a9));
		foreach (b[i]) b[i] = 8'($urandom);
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		rd(`KSS_CD_CTRL, 8'h05);
		chk({7'h0, tx_buffer_free_n}, 8'h01);
		wr(`KSS_CD_CTRL, 8'h4e);
		wr(`KSS_CD_CTRL, 8'h06);
		chk({7'h0, vector_relocate_n}, 8'h00);
		// character loaded with transmit disabled must wait in the buffer
		wr(`KSS_CD_DATA, b[0]);
		rd(`KSS_CD_CTRL, 8'h00);
		repeat (100) @(negedge clk);
		chk({7'h0, keyboard_serial_out}, 8'h01);
		chk({7'h0, tx_buffer_free_n}, 8'h01);
		exp_tx.push_back(b[0]);
		wr(`KSS_CD_CTRL, 8'h07);
		repeat (20) @(negedge clk);
		chk({7'h0, tx_buffer_free_n}, 8'h00);
		chk({7'h0, keyboard_irq_n}, 8'h00);
		wait_tx(1);
		// receive a clean character
		u_kss_kb_model.send(b[1], 1'b1);
		wait_rx();
		chk({7'h0, rx_char_waiting_n}, 8'h00);
		rd(`KSS_CD_CTRL, 8'h07);
		rd(`KSS_CD_DATA, b[1]);
		chk({7'h0, rx_char_waiting_n}, 8'h01);
		// framing fault, then error reset
		u_kss_kb_model.send(b[2], 1'b0);
		wait_rx();
		rd(`KSS_CD_CTRL, 8'h27);
		// second character while the first is unread gives an overrun
		u_kss_kb_model.send(b[1], 1'b1);
		rd(`KSS_CD_CTRL, 8'h37);
		rd(`KSS_CD_DATA, b[1]);
		wr(`KSS_CD_CTRL, 8'h17);
		rd(`KSS_CD_CTRL, 8'h05);
		// a short low pulse is not a start bit
		u_kss_kb_model.glitch();
		chk({7'h0, rx_char_waiting_n}, 8'h01);
		// internal reset, new mode with two stop bits, back-to-back characters
		wr(`KSS_CD_CTRL, 8'h40);
		chk({7'h0, vector_relocate_n}, 8'h01);
		wr(`KSS_CD_CTRL, 8'hce);
		wr(`KSS_CD_CTRL, 8'h07);
		exp_tx.push_back(b[3]);
		exp_tx.push_back(b[4]);
		wr(`KSS_CD_DATA, b[3]);
		wait_tx(1);
		wr(`KSS_CD_DATA, b[4]);
		chk({7'h0, tx_buffer_free_n}, 8'h01);
		wait_tx(3);
		chk({7'h0, u_kss_kb_model.flen >= 175 && u_kss_kb_model.flen <= 177}, 8'h01);
		// init pin idles the port until control words come again
		@(negedge clk);
		init_n = 1'b0;
		repeat (6) @(negedge clk);
		init_n = 1'b1;
		repeat (4) @(negedge clk);
		chk({6'h0, tx_buffer_free_n, vector_relocate_n}, 8'h03);
		rd(`KSS_CD_CTRL, 8'h05);
		wr(`KSS_CD_CTRL, 8'h4e);
		wr(`KSS_CD_CTRL, 8'h07);
		chk({7'h0, tx_buffer_free_n}, 8'h00);
		chk(8'(exp_rd.size() + exp_tx.size()), 8'h00);
		print_verdict();
	end
endmodule
